// ### core/crl_config.v
// Top of the bit-sync loop and AGC limit configuration block with its register port.
// Assumes a synchronous byte register port; sync and reception events come from modem logic.
// Decoded limits and loop gains leave the block straight from flip-flops.
`timescale 1ns/10ps
`include "crl_map.vh"
module crl_config
(
    input  wire       clk,             // Digital clock, 25 MHz
    input  wire       nrst,            // Async reset, active low
    input  wire [5:0] reg_addr,        // Register address
    input  wire       reg_wr,          // Write strobe
    input  wire       reg_rd,          // Read strobe
    input  wire [7:0] reg_wdata,       // Write data
    output reg  [7:0] reg_rdata_r,     // Read data
    input  wire       sync_found,      // Sync word detected pulse
    input  wire       rx_start,        // New reception begins pulse
    output reg        sync_locked_r,   // Post-sync gains in use
    output wire [3:0] ki_gain_r,       // Integral gain, base/2 units
    output wire [3:0] kp_gain_r,       // Proportional gain, base/2 units
    output reg  [6:0] rate_lim_r,      // Max rate offset, 1/8 percent units
    output reg        rate_comp_en_r,  // Offset compensation enabled
    output reg  [2:0] dgain_max_r,     // Highest usable digital gain index
    output reg  [2:0] fgain_cap_r,     // Front-end gain cap step, 0 = max
    output reg  [5:0] tgt_db_r         // Amplitude target in dB
);
    // Register images and their next values
    reg  [7:0] bsync_r;
    reg  [7:0] bsync_nxt;
    reg  [7:0] agc_r;
    reg  [7:0] agc_nxt;
    reg  [7:0] reg_rdata_nxt;
    reg        lock_nxt;

    // Decoded limit next values
    reg  [6:0] rate_lim_nxt;
    reg        rate_comp_en_nxt;
    reg  [2:0] dgain_max_nxt;
    reg  [2:0] fgain_cap_nxt;
    reg  [5:0] tgt_db_nxt;

    // Write enables for the two registers
    wire       bsync_wr;
    wire       agc_wr;

    // Named fields of the bit-sync loop register
    wire [1:0] pre_sync_integral_gain_sel;
    wire [1:0] pre_sync_proportional_gain_sel;
    wire       post_sync_integral_gain_sel;
    wire       post_sync_proportional_gain_sel;
    wire [1:0] rate_offset_saturation;

    // Named fields of the AGC limit register
    wire [1:0] digital_gain_cap;
    wire [2:0] front_end_gain_cap;
    wire [2:0] amplitude_target_sel;

    // Address match, shared by the write and read decodes
    function addr_hit;
        input [5:0] addr;
        input [5:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Offset saturation code to limit in 1/8 percent units
    function [6:0] rate_lim;
        input [1:0] code;
        begin
            case (code)
                `CRL_LIMIT_3P125: rate_lim = `CRL_LIM_3P125_VAL; // RULE3
                `CRL_LIMIT_6P25:  rate_lim = `CRL_LIM_6P25_VAL;  // RULE3
                `CRL_LIMIT_12P5:  rate_lim = `CRL_LIM_12P5_VAL;  // RULE3
                default:          rate_lim = `CRL_LIM_OFF_VAL;   // RULE4
            endcase
        end
    endfunction

    // Amplitude target code to dB
    function [5:0] tgt_db;
        input [2:0] code;
        begin
            case (code)
                3'h0: tgt_db = 6'h18;
                3'h1: tgt_db = 6'h1B;
                3'h2: tgt_db = 6'h1E;
                3'h3: tgt_db = 6'h21;
                3'h4: tgt_db = 6'h24;
                3'h5: tgt_db = 6'h26;
                3'h6: tgt_db = 6'h28;
                default: tgt_db = 6'h2A;
            endcase
        end
    endfunction

    // Write enables; writes to any other address are ignored
    assign bsync_wr = reg_wr && addr_hit(reg_addr, `CRL_ADDR_BSYNC);
    assign agc_wr   = reg_wr && addr_hit(reg_addr, `CRL_ADDR_AGC);

    // Next register images
    always @*
    begin
        bsync_nxt = bsync_r;
        agc_nxt   = agc_r;
        if (bsync_wr)
            bsync_nxt = reg_wdata;
        if (agc_wr)
            agc_nxt = reg_wdata;
    end

    // Read data; a read in the same cycle as a write returns the old value
    // Unmapped addresses read as zero, and the data holds between reads
    always @*
    begin
        reg_rdata_nxt = reg_rdata_r;
        if (reg_rd)
        begin
            if (addr_hit(reg_addr, `CRL_ADDR_BSYNC))
                reg_rdata_nxt = bsync_r;
            else if (addr_hit(reg_addr, `CRL_ADDR_AGC))
                reg_rdata_nxt = agc_r;
            else
                reg_rdata_nxt = 8'h00;
        end
    end

    // Register images and read data
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bsync_r     <= `CRL_BSYNC_RST; // RULE4
            agc_r       <= `CRL_AGC_RST;   // RULE7
            reg_rdata_r <= 8'h00;
        end
        else
        begin
            bsync_r     <= bsync_nxt;
            agc_r       <= agc_nxt;
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    // Field views of the bit-sync loop register
    assign pre_sync_integral_gain_sel      = bsync_r[`CRL_PRE_KI_HI:`CRL_PRE_KI_LO];
    assign pre_sync_proportional_gain_sel  = bsync_r[`CRL_PRE_KP_HI:`CRL_PRE_KP_LO];
    assign post_sync_integral_gain_sel     = bsync_r[`CRL_POST_KI_BIT];
    assign post_sync_proportional_gain_sel = bsync_r[`CRL_POST_KP_BIT];
    assign rate_offset_saturation          = bsync_r[`CRL_LIMIT_HI:`CRL_LIMIT_LO];

    // Field views of the AGC limit register
    assign digital_gain_cap     = agc_r[`CRL_DGAIN_HI:`CRL_DGAIN_LO];
    assign front_end_gain_cap   = agc_r[`CRL_FGAIN_HI:`CRL_FGAIN_LO];
    assign amplitude_target_sel = agc_r[`CRL_TGT_HI:`CRL_TGT_LO];

    // Loop phase: sync detection wins over a simultaneous reception start
    // The gain selectors see the next phase, so gains switch on the detection edge
    always @*
    begin
        lock_nxt = sync_locked_r;
        if (rx_start)
            lock_nxt = 1'b0; // RULE10
        if (sync_found)
            lock_nxt = 1'b1; // RULE10
    end

    // Decoded limits for the loop and AGC
    always @*
    begin
        rate_lim_nxt     = rate_lim(rate_offset_saturation); // RULE3 RULE4
        rate_comp_en_nxt = (rate_offset_saturation != `CRL_LIMIT_OFF); // RULE4
        dgain_max_nxt    = `CRL_DGAIN_TOP - {1'b0, digital_gain_cap}; // RULE5
        fgain_cap_nxt    = front_end_gain_cap; // RULE6
        tgt_db_nxt       = tgt_db(amplitude_target_sel); // RULE7
    end

    // Decoded outputs and loop phase, straight from flip-flops
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_locked_r  <= 1'b0;
            rate_lim_r     <= `CRL_LIM_OFF_VAL;
            rate_comp_en_r <= 1'b0;
            dgain_max_r    <= `CRL_DGAIN_TOP;
            fgain_cap_r    <= 3'h0;
            tgt_db_r       <= `CRL_TGT_RST_DB;
        end
        else
        begin
            sync_locked_r  <= lock_nxt;
            rate_lim_r     <= rate_lim_nxt;
            rate_comp_en_r <= rate_comp_en_nxt;
            dgain_max_r    <= dgain_max_nxt;
            fgain_cap_r    <= fgain_cap_nxt;
            tgt_db_r       <= tgt_db_nxt;
        end
    end

    // Integral gain path; post code 1 gives half the base gain
    crl_gain_sel u_ki
    (
        .clk       (clk),
        .nrst      (nrst),
        .pre_sel   (pre_sync_integral_gain_sel),
        .post_sel  (post_sync_integral_gain_sel),
        .half_post (1'b1),
        .locked    (lock_nxt),
        .gain_r    (ki_gain_r)
    );

    // Proportional gain path; post code 1 gives the base gain
    crl_gain_sel u_kp
    (
        .clk       (clk),
        .nrst      (nrst),
        .pre_sel   (pre_sync_proportional_gain_sel),
        .post_sel  (post_sync_proportional_gain_sel),
        .half_post (1'b0),
        .locked    (lock_nxt),
        .gain_r    (kp_gain_r)
    );
endmodule

// ### include/crl_map.vh
// Register map and field constants for the bit-sync loop and AGC limit configuration block.
// Assumes a byte-wide register port with 6-bit addresses and a digital clock of 25 MHz.
// Summary of operation
// RULE1: After sync, integral gain bit 0 keeps pre-sync gain, 1 halves base gain.
// RULE2: After sync, proportional gain bit 0 keeps pre-sync gain, 1 uses base gain.
// RULE3: Offset limit codes 1,2,3 clamp correction to 3.125, 6.25, 12.5 percent.
// RULE4: Offset limit code 0, the reset value, disables data-rate offset compensation.
// RULE5: Bits 7:6 bar that many top digital gain settings from the AGC.
// RULE6: Bits 5:3 cap front-end gain; 0 maximum, 7 about 17.1 dB lower.
// RULE7: Bits 2:0 pick amplitude target 24..42 dB; reset code 3 (33 dB).
// RULE8: Before sync, integral gain is one to four times base, per two-bit field.
// RULE9: Before sync, proportional gain is a multiple of base, per two-bit field.
// RULE10: Gains switch to post-sync on sync detection, back at new reception start.
`ifndef CRL_MAP_VH
`define CRL_MAP_VH
`define CRL_ADDR_BSYNC      6'h1A
`define CRL_ADDR_AGC        6'h1B
`define CRL_BSYNC_RST       8'h6C
`define CRL_AGC_RST         8'h03
`define CRL_PRE_KI_HI       7
`define CRL_PRE_KI_LO       6
`define CRL_PRE_KP_HI       5
`define CRL_PRE_KP_LO       4
`define CRL_POST_KI_BIT     3
`define CRL_POST_KP_BIT     2
`define CRL_LIMIT_HI        1
`define CRL_LIMIT_LO        0
`define CRL_DGAIN_HI        7
`define CRL_DGAIN_LO        6
`define CRL_FGAIN_HI        5
`define CRL_FGAIN_LO        3
`define CRL_TGT_HI          2
`define CRL_TGT_LO          0
`define CRL_LIMIT_OFF       2'h0
`define CRL_LIMIT_3P125     2'h1
`define CRL_LIMIT_6P25      2'h2
`define CRL_LIMIT_12P5      2'h3
`define CRL_DGAIN_TOP       3'h7
`define CRL_GAIN_BASE       4'h2
`define CRL_GAIN_HALF       4'h1
`define CRL_LIM_OFF_VAL     7'h00
`define CRL_LIM_3P125_VAL   7'h19
`define CRL_LIM_6P25_VAL    7'h32
`define CRL_LIM_12P5_VAL    7'h64
`define CRL_TGT_RST_DB      6'h21
`endif

// ### core/crl_gain_sel.v
// Loop gain selector: maps pre/post gain fields to a gain in half-steps of the base gain.
// Assumes the caller supplies the sync-locked phase flag on the same clock.
`timescale 1ns/10ps
`include "crl_map.vh"
module crl_gain_sel
(
    input  wire       clk,       // Digital clock
    input  wire       nrst,      // Async reset, active low
    input  wire [1:0] pre_sel,   // Pre-sync multiplier code
    input  wire       post_sel,  // Post-sync select bit
    input  wire       half_post, // 1: post code 1 means base/2
    input  wire       locked,    // Post-sync phase
    output reg  [3:0] gain_r     // Gain in units of base/2
);
    reg [3:0] gain_nxt;

    // Pre-sync multiple (code+1) times base, in half units
    function [3:0] pre_gain;
        input [1:0] code;
        begin
            pre_gain = {1'b0, code, 1'b0} + `CRL_GAIN_BASE;
        end
    endfunction

    // Choose the gain for the current loop phase
    always @*
    begin
        gain_nxt = pre_gain(pre_sel); // RULE8 RULE9
        if (locked && post_sel)
            gain_nxt = half_post ? `CRL_GAIN_HALF : `CRL_GAIN_BASE; // RULE1 RULE2
    end

    // Registered gain output
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            gain_r <= 4'h0;
        else
            gain_r <= gain_nxt;
    end
endmodule

// ### tb/crl_config_sva.sv
// Checker: port-level properties of the loop gain and AGC limit block.
// Assumes a bind onto crl_config; sees only its ports.
`timescale 1ns/10ps
module crl_sva
(
    input wire logic       clk,             // Digital clock
    input wire logic       nrst,            // Async reset, active low
    input wire logic [5:0] reg_addr,        // Register address
    input wire logic       reg_wr,          // Write strobe
    input wire logic [7:0] reg_wdata,       // Write data
    input wire logic       sync_found,      // Sync word detected pulse
    input wire logic       rx_start,        // Reception start pulse
    input wire logic       sync_locked_r,   // Post-sync phase
    input wire logic [3:0] ki_gain_r,       // Integral gain
    input wire logic [3:0] kp_gain_r,       // Proportional gain
    input wire logic [6:0] rate_lim_r,      // Rate offset limit
    input wire logic       rate_comp_en_r,  // Offset compensation on
    input wire logic [2:0] dgain_max_r,     // Top digital gain index
    input wire logic [2:0] fgain_cap_r,     // Front-end gain cap
    input wire logic [5:0] tgt_db_r         // Amplitude target, dB
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Write decodes for the two registers
    wire wa = reg_wr && reg_addr == 6'h1B;
    wire wb = reg_wr && reg_addr == 6'h1A;
    // Expected limit per code in 1/8 percent units: 3.125, 6.25, 12.5 percent
    function automatic logic [6:0] lim_exp(input logic [1:0] code);
        case (code)
            2'h1: return 7'h19;
            2'h2: return 7'h32;
            2'h3: return 7'h64;
            default: return 7'h00;
        endcase
    endfunction
    property p_lk; sync_found |=> sync_locked_r; endproperty
    a_lk: assert property (p_lk) else $error("no lock");
    property p_ul; rx_start && !sync_found |=> !sync_locked_r; endproperty
    a_ul: assert property (p_ul) else $error("no unlock");
    property p_dg; wa |-> ##2 {5'h00, dgain_max_r} + ($past(reg_wdata, 2) >> 6) == 8'h07; endproperty
    a_dg: assert property (p_dg) else $error("digital cap");
    property p_fc; wa |-> ##2 {5'h00, fgain_cap_r} == ($past(reg_wdata, 2) >> 3 & 8'h07); endproperty
    a_fc: assert property (p_fc) else $error("front cap");
    property p_tg; wa && reg_wdata[2:0] == 3'h7 |-> ##2 tgt_db_r == 6'd42; endproperty
    a_tg: assert property (p_tg) else $error("target");
    property p_lm;
        wb && reg_wdata[1:0] != 2'h0 |->
            ##2 rate_lim_r == lim_exp($past(reg_wdata[1:0], 2)) && rate_comp_en_r;
    endproperty
    a_lm: assert property (p_lm) else $error("limit");
    property p_nc; wb && reg_wdata[1:0] == 2'h0 |-> ##2 rate_lim_r == 7'h00 && !rate_comp_en_r; endproperty
    a_nc: assert property (p_nc) else $error("no compensation");
    property p_ki; ki_gain_r[0] |-> ki_gain_r == 4'h1 && sync_locked_r; endproperty
    a_ki: assert property (p_ki) else $error("post ki");
    // On lock, kp is the base gain or keeps its pre-sync value
    property p_kp; $rose(sync_locked_r) && !$past(wb, 2) |-> kp_gain_r == 4'h2 || $stable(kp_gain_r); endproperty
    a_kp: assert property (p_kp) else $error("post kp");
    c_lk: cover property (sync_found ##1 sync_locked_r);
    c_wa: cover property (wa);
    c_wb: cover property (wb ##2 rate_comp_en_r);
endmodule

// ### tb/tb_clock_recovery_agc_limit_config.sv
// Bench: register writes, reads and sync events on the config block.
// Assumes crl_config and its checker are compiled before this file.
`timescale 1ns/10ps
module tb_clock_recovery_agc_limit_config;
    logic       clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, sync_found = 0, rx_start = 0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    wire  [7:0] reg_rdata_r;
    wire        sync_locked_r, rate_comp_en_r;
    wire  [3:0] ki_gain_r, kp_gain_r;
    wire  [6:0] rate_lim_r;
    wire  [2:0] dgain_max_r, fgain_cap_r;
    wire  [5:0] tgt_db_r;
    int         fail_count = 0, comparisons = 0;
    logic [5:0] tdb [8] = '{6'd24, 6'd27, 6'd30, 6'd33, 6'd36, 6'd38, 6'd40, 6'd42};
    // Rate limits in 1/8 percent units: off, 3.125, 6.25, 12.5 percent
    logic [6:0] lim [4] = '{7'h00, 7'h19, 7'h32, 7'h64};
    crl_config dut_u
    (
        .clk            (clk),
        .nrst           (nrst),
        .reg_addr       (reg_addr),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_wdata      (reg_wdata),
        .reg_rdata_r    (reg_rdata_r),
        .sync_found     (sync_found),
        .rx_start       (rx_start),
        .sync_locked_r  (sync_locked_r),
        .ki_gain_r      (ki_gain_r),
        .kp_gain_r      (kp_gain_r),
        .rate_lim_r     (rate_lim_r),
        .rate_comp_en_r (rate_comp_en_r),
        .dgain_max_r    (dgain_max_r),
        .fgain_cap_r    (fgain_cap_r),
        .tgt_db_r       (tgt_db_r)
    );
    // 40 ns clock
    initial forever #20 clk = ~clk;
    // Compare and count
    task chk(input logic [7:0] g, e);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %0t: mismatch, got %h expected %h", $time, g, e);
        end
    endtask
    // Write, then wait two edges for the outputs
    task put(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk) reg_wr = 0;
        repeat (2) @(negedge clk);
    endtask
    // Read, data checked one edge later
    task get(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk) reg_rd = 0;
        chk(reg_rdata_r, e);
    endtask
    // One-cycle sync and reception-start pulses
    task pls(input logic s, r);
        @(negedge clk) {sync_found, rx_start} = {s, r};
        @(negedge clk) {sync_found, rx_start} = 2'b00;
    endtask
    task t_rst;
        get(6'h1A, 8'h6C);
        get(6'h1B, 8'h03);
        chk(ki_gain_r, 8'h04);
        chk(kp_gain_r, 8'h06);
        chk(tgt_db_r, 8'h21);
        chk(rate_comp_en_r, 8'h00);
        chk(rate_lim_r, 8'h00);
        chk(dgain_max_r, 8'h07);
        chk(fgain_cap_r, 8'h00);
        put(6'h1C, 8'hA5);
        get(6'h1C, 8'h00);
        $display("reset and map test done");
    endtask
    task t_agc;
        for (int i = 0; i < 8; i++)
        begin
            put(6'h1B, {i[1:0], i[2:0], i[2:0]});
            chk(tgt_db_r, tdb[i]);
            chk(dgain_max_r, 3'h7 - i[1:0]);
            chk(fgain_cap_r, i[2:0]);
        end
        $display("agc test done");
    endtask
    task t_lim;
        for (int c = 3; c >= 0; c--)
        begin
            put(6'h1A, {6'h1B, c[1:0]});
            chk(rate_comp_en_r, c != 0);
            chk(rate_lim_r, lim[c]);
        end
        chk(rate_lim_r, 8'h00);
        put(6'h1A, 8'h6D);
        chk(rate_lim_r, 8'h19);
        $display("limit test done");
    endtask
    task t_sync;
        pls(1, 0);
        chk(sync_locked_r, 8'h01);
        chk(ki_gain_r, 8'h01);
        chk(kp_gain_r, 8'h02);
        pls(0, 1);
        chk(sync_locked_r, 8'h00);
        chk(ki_gain_r, 8'h04);
        chk(kp_gain_r, 8'h06);
        put(6'h1A, 8'hF0);
        pls(1, 1);
        chk(sync_locked_r, 8'h01);
        chk(ki_gain_r, 8'h08);
        chk(kp_gain_r, 8'h08);
        $display("sync test done");
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Reset for five cycles, then the scenarios
    initial
    begin
        repeat (5) @(negedge clk);
        nrst = 1;
        t_rst; t_agc; t_lim; t_sync;
        conclude;
    end
    // Watchdog at 2500 cycles, far beyond the 77 or so cycles needed
    initial
    begin
        #100us;
        fail_count++;
        conclude;
    end
endmodule
bind crl_config crl_sva chk_u
(
    .clk            (clk),
    .nrst           (nrst),
    .reg_addr       (reg_addr),
    .reg_wr         (reg_wr),
    .reg_wdata      (reg_wdata),
    .sync_found     (sync_found),
    .rx_start       (rx_start),
    .sync_locked_r  (sync_locked_r),
    .ki_gain_r      (ki_gain_r),
    .kp_gain_r      (kp_gain_r),
    .rate_lim_r     (rate_lim_r),
    .rate_comp_en_r (rate_comp_en_r),
    .dgain_max_r    (dgain_max_r),
    .fgain_cap_r    (fgain_cap_r),
    .tgt_db_r       (tgt_db_r)
);
